// file: hw/gateway_pkg.sv
// Purpose: shared constants and types for the serial slave / fieldbus gateway
// Assumes: byte-wide serial stream, 16-bit frame check
// Notes: state codes form a gray sequence in declaration order
package gateway_pkg;

    localparam logic [7:0] FC_READ_COILS = 8'h01;
    localparam logic [7:0] FC_READ_DISCRETE = 8'h02;
    localparam logic [7:0] FC_READ_HOLDING = 8'h03;
    localparam logic [7:0] FC_READ_INPUT = 8'h04;

    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;

    localparam int FRAME_MIN = 4;
    localparam int FRAME_OVERHEAD = 3;
    localparam int LOCAL_HDR = 2;
    localparam int BIT_GROUP_SHIFT = 3;
    localparam int BIT_ROUND = 7;
    localparam int REG_BYTES_SHIFT = 1;
    localparam int TRIG_POS = 0;

    localparam int IDX_ADDR = 0;
    localparam int IDX_FC = 1;
    localparam int IDX_START_HI = 2;
    localparam int IDX_START_LO = 3;
    localparam int IDX_QTY_HI = 4;
    localparam int IDX_QTY_LO = 5;

    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] SEQ_STEP = 8'h01;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_FWD = 4'h1,
        ST_HDR = 4'h3,
        ST_SCAN = 4'h2,
        ST_COPY = 4'h6,
        ST_TX_FETCH = 4'h7,
        ST_TX_LOAD = 4'h5,
        ST_TX_SEND = 4'h4
    } gw_state_e;

    function automatic logic is_local_fc(input logic [7:0] fc);
        return (fc >= FC_READ_COILS) && (fc <= FC_READ_INPUT);
    endfunction : is_local_fc

    function automatic logic is_bit_fc(input logic [7:0] fc);
        return (fc == FC_READ_COILS) || (fc == FC_READ_DISCRETE);
    endfunction : is_bit_fc

endpackage : gateway_pkg

// file: hw/frame_crc16.sv
// Purpose: one-byte step of the reflected 16-bit frame check
// Assumes: caller holds the running value in a register
// Notes: purely combinational
`timescale 1ns/10ps
module frame_crc16
    import gateway_pkg::*;
(
    input wire logic [15:0] crc_in,
    input wire logic [7:0] data,
    output logic [15:0] crc_out
);

    always_comb
    begin
        crc_out = crc_in ^ {8'h00, data};
        for (int i = 0; i < 8; i++)
        begin
            crc_out = crc_out[0] ? ((crc_out >> 1) ^ CRC_POLY) : (crc_out >> 1);
        end
    end

endmodule : frame_crc16

// file: hw/byte_buffer.sv
// Purpose: single write port, single registered read port byte store
// Assumes: write and read addresses are in range
// Notes: array itself carries no reset, only the read register does
`timescale 1ns/10ps
module byte_buffer #(
    parameter int DEPTH = 64,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata
);

    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata <= 8'h00;
        end
        else
        begin
            rdata <= mem[raddr];
        end
    end

endmodule : byte_buffer

// file: hw/modbus_slave_fieldbus_gateway.sv
// Purpose: serial slave that tunnels requests to a cyclic fieldbus master
// Assumes: byte stream from an outside receiver, frame end flagged after the gap
// Notes: stored copy of the fieldbus output serves replies and local reads
// Function
// - act only when first byte equals address
// - forward frame without address and check bytes
// - optional counter byte then count byte first
// - counter byte advances once per request
// - count byte holds following request byte count
// - reply gets address prefix and check suffix
// - after reply go idle, one exchange each
// - change mode sends only when buffer differs
// - counter mode sends only on counter change
// - counter mode uses first buffer byte
// - count byte follows counter, data after
// - take only counted bytes, keep the rest
// - received byte count written into count byte
// - function codes one, two read stored bits
// - bit reads align start down to eight
// - function codes three, four read stored registers
`timescale 1ns/10ps
module modbus_slave_fieldbus_gateway
    import gateway_pkg::*;
#(
    parameter int FB_LEN = 64,
    parameter int RX_MAX = 256,
    parameter int AW = $clog2(FB_LEN),
    parameter int SW = $clog2(RX_MAX)
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] slave_id_high_switch,
    input wire logic [3:0] slave_id_low_switch,
    input wire logic trig_en,
    input wire logic len_en,
    input wire logic local_regs_en,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_frame_end,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic fb_out_we,
    input wire logic [AW-1:0] fb_out_addr,
    input wire logic [7:0] fb_out_data,
    input wire logic fb_out_commit,
    input wire logic [AW-1:0] fb_in_addr,
    output logic [7:0] fb_in_data,
    output logic req_pending
);

    gw_state_e st_r;
    logic [7:0] slave_address;
    logic [AW:0] hdr_len;
    logic [AW:0] data_max;
    logic [AW-1:0] len_pos;
    logic [15:0] take16;
    logic [15:0] span16;
    logic [SW:0] rx_cnt_r;
    logic [15:0] crc_rx_r;
    logic [15:0] crc_rx_nxt;
    logic [7:0] req_addr_r;
    logic [7:0] req_fc_r;
    logic [15:0] req_start_r;
    logic [15:0] req_qty_r;
    logic frame_rdy_r;
    logic frame_ok_r;
    logic [SW:0] frame_len_r;
    logic commit_pend_r;
    logic [7:0] trig_in_r;
    logic [7:0] len_in_r;
    logic take_frame;
    logic take_commit;
    logic [15:0] cp_r;
    logic wv_r;
    logic [15:0] wa_r;
    logic diff_r;
    logic seeded_r;
    logic hdr_ph_r;
    logic pending_r;
    logic [7:0] seq_r;
    logic [7:0] last_trig_r;
    logic [15:0] plen_r;
    logic [15:0] fwd_len;
    logic [17:0] loc_bc;
    logic [17:0] loc_base;
    logic tx_local_r;
    logic [17:0] tx_base_r;
    logic [17:0] tx_body_r;
    logic [17:0] tx_idx_r;
    logic [7:0] tx_bc_r;
    logic [17:0] body_addr;
    logic oob_r;
    logic [7:0] tx_pick;
    logic [15:0] crc_tx_r;
    logic [15:0] crc_tx_nxt;
    logic tx_valid_r;
    logic [7:0] tx_data_r;
    logic tx_done;
    logic [7:0] stg_rdata;
    logic [7:0] out_rdata;
    logic [7:0] sto_rdata;
    logic in_we;
    logic [AW-1:0] in_waddr;
    logic [7:0] in_wdata;
    logic [AW-1:0] sto_raddr;

    assign slave_address = {slave_id_high_switch, slave_id_low_switch};
    // header size follows the options set up before traffic starts
    assign hdr_len = (AW+1)'(trig_en) + (AW+1)'(len_en);
    assign len_pos = AW'(trig_en);
    assign data_max = (AW+1)'(FB_LEN) - hdr_len;
    assign take16 = (len_en && (16'(len_in_r) < 16'(data_max))) ? 16'(len_in_r)
        : 16'(data_max);
    assign span16 = 16'(hdr_len) + take16;
    assign fwd_len = (16'(frame_len_r) - 16'(FRAME_OVERHEAD) < 16'(data_max))
        ? 16'(frame_len_r) - 16'(FRAME_OVERHEAD) : 16'(data_max);
    assign take_frame = (st_r == ST_IDLE) && frame_rdy_r;
    assign take_commit = (st_r == ST_IDLE) && !frame_rdy_r && commit_pend_r;
    assign tx_done = (st_r == ST_TX_SEND) && tx_ready && (tx_idx_r == tx_body_r + 18'd2);
    assign tx_valid = tx_valid_r;
    assign tx_data = tx_data_r;
    assign req_pending = pending_r;

    frame_crc16 u_crc_rx (.crc_in(crc_rx_r), .data(rx_data), .crc_out(crc_rx_nxt));
    frame_crc16 u_crc_tx (.crc_in(crc_tx_r), .data(tx_data_r), .crc_out(crc_tx_nxt));

    byte_buffer #(.DEPTH(RX_MAX), .AW(SW)) u_stage (
        .clk(clk), .arst_n(arst_n),
        .we(rx_valid && (rx_cnt_r < (SW+1)'(RX_MAX))),
        .waddr(rx_cnt_r[SW-1:0]), .wdata(rx_data),
        .raddr(SW'(cp_r + 16'd1)), .rdata(stg_rdata)
    );
    byte_buffer #(.DEPTH(FB_LEN), .AW(AW)) u_out (
        .clk(clk), .arst_n(arst_n), .we(fb_out_we), .waddr(fb_out_addr),
        .wdata(fb_out_data), .raddr(cp_r[AW-1:0]), .rdata(out_rdata)
    );
    byte_buffer #(.DEPTH(FB_LEN), .AW(AW)) u_store (
        .clk(clk), .arst_n(arst_n), .we((st_r == ST_COPY) && wv_r),
        .waddr(wa_r[AW-1:0]), .wdata(out_rdata), .raddr(sto_raddr), .rdata(sto_rdata)
    );
    byte_buffer #(.DEPTH(FB_LEN), .AW(AW)) u_in (
        .clk(clk), .arst_n(arst_n), .we(in_we), .waddr(in_waddr),
        .wdata(in_wdata), .raddr(fb_in_addr), .rdata(fb_in_data)
    );

    // receive side runs regardless of the sequencer; the master waits for its reply
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_cnt_r <= '0;
            crc_rx_r <= CRC_INIT;
            req_addr_r <= BYTE_ZERO;
            req_fc_r <= BYTE_ZERO;
            req_start_r <= 16'h0000;
            req_qty_r <= 16'h0000;
        end
        else if (rx_frame_end)
        begin
            rx_cnt_r <= '0;
            crc_rx_r <= CRC_INIT;
        end
        else if (rx_valid)
        begin
            rx_cnt_r <= (rx_cnt_r < (SW+1)'(RX_MAX)) ? rx_cnt_r + 1'b1 : rx_cnt_r;
            crc_rx_r <= crc_rx_nxt;
            if (rx_cnt_r == (SW+1)'(IDX_ADDR))
                req_addr_r <= rx_data;
            if (rx_cnt_r == (SW+1)'(IDX_FC))
                req_fc_r <= rx_data;
            if (rx_cnt_r == (SW+1)'(IDX_START_HI))
                req_start_r[15:8] <= rx_data;
            if (rx_cnt_r == (SW+1)'(IDX_START_LO))
                req_start_r[7:0] <= rx_data;
            if (rx_cnt_r == (SW+1)'(IDX_QTY_HI))
                req_qty_r[15:8] <= rx_data;
            if (rx_cnt_r == (SW+1)'(IDX_QTY_LO))
                req_qty_r[7:0] <= rx_data;
        end
    end

    // a new frame end wins over the sequencer taking the previous one
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            frame_rdy_r <= 1'b0;
            frame_ok_r <= 1'b0;
            frame_len_r <= '0;
        end
        else if (rx_frame_end)
        begin
            frame_rdy_r <= 1'b1;
            frame_len_r <= rx_cnt_r;
            frame_ok_r <= (rx_cnt_r >= (SW+1)'(FRAME_MIN)) && (rx_cnt_r < (SW+1)'(RX_MAX))
                && (crc_rx_r == CRC_RESIDUE) && (req_addr_r == slave_address);
        end
        else if (take_frame)
        begin
            frame_rdy_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            commit_pend_r <= 1'b0;
            trig_in_r <= BYTE_ZERO;
            len_in_r <= BYTE_ZERO;
        end
        else
        begin
            if (fb_out_commit)
                commit_pend_r <= 1'b1;
            else if (take_commit)
                commit_pend_r <= 1'b0;
            if (fb_out_we && (fb_out_addr == AW'(TRIG_POS)))
                trig_in_r <= fb_out_data;
            if (fb_out_we && (fb_out_addr == len_pos))
                len_in_r <= fb_out_data;
        end
    end

    always_comb
    begin
        if (is_bit_fc(req_fc_r))
        begin
            loc_bc = (18'(req_qty_r) + 18'(BIT_ROUND)) >> BIT_GROUP_SHIFT;
            loc_base = 18'(hdr_len) + (18'(req_start_r) >> BIT_GROUP_SHIFT);
        end
        else
        begin
            loc_bc = 18'(req_qty_r) << REG_BYTES_SHIFT;
            loc_base = 18'(hdr_len) + (18'(req_start_r) << REG_BYTES_SHIFT);
        end
    end

    assign body_addr = tx_base_r + tx_idx_r - 18'd1 - (tx_local_r ? 18'(LOCAL_HDR) : 18'd0);
    assign sto_raddr = (st_r == ST_TX_FETCH) ? body_addr[AW-1:0] : cp_r[AW-1:0];

    always_comb
    begin
        in_we = 1'b0;
        in_waddr = wa_r[AW-1:0];
        in_wdata = stg_rdata;
        if (st_r == ST_FWD)
        begin
            in_we = wv_r;
        end
        else if (st_r == ST_HDR)
        begin
            in_we = hdr_ph_r ? trig_en : len_en;
            in_waddr = hdr_ph_r ? AW'(TRIG_POS) : len_pos;
            in_wdata = hdr_ph_r ? seq_r + SEQ_STEP : plen_r[7:0];
        end
    end

    always_comb
    begin
        if (tx_idx_r == 18'd0)
            tx_pick = slave_address;
        else if (tx_idx_r <= tx_body_r)
        begin
            if (tx_local_r && (tx_idx_r == 18'd1))
                tx_pick = req_fc_r;
            else if (tx_local_r && (tx_idx_r == 18'd2))
                tx_pick = tx_bc_r;
            else
                tx_pick = oob_r ? BYTE_ZERO : sto_rdata;
        end
        else if (tx_idx_r == tx_body_r + 18'd1)
            tx_pick = crc_tx_r[7:0];
        else
            tx_pick = crc_tx_r[15:8];
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r <= ST_IDLE;
            cp_r <= 16'h0000;
            wv_r <= 1'b0;
            wa_r <= 16'h0000;
            diff_r <= 1'b0;
            seeded_r <= 1'b0;
            hdr_ph_r <= 1'b0;
            pending_r <= 1'b0;
            seq_r <= BYTE_ZERO;
            last_trig_r <= BYTE_ZERO;
            plen_r <= 16'h0000;
            tx_local_r <= 1'b0;
            tx_base_r <= '0;
            tx_body_r <= '0;
            tx_idx_r <= '0;
            tx_bc_r <= BYTE_ZERO;
            oob_r <= 1'b0;
            crc_tx_r <= CRC_INIT;
            tx_valid_r <= 1'b0;
            tx_data_r <= BYTE_ZERO;
        end
        else
        begin
            unique case (st_r)
                ST_IDLE:
                begin
                    cp_r <= 16'h0000;
                    wv_r <= 1'b0;
                    diff_r <= 1'b0;
                    hdr_ph_r <= 1'b0;
                    tx_idx_r <= '0;
                    crc_tx_r <= CRC_INIT;
                    if (take_frame && frame_ok_r)
                    begin
                        if (local_regs_en && is_local_fc(req_fc_r))
                        begin
                            // the serial master's request is the only trigger for a reply
                            tx_local_r <= 1'b1;
                            tx_base_r <= loc_base;
                            tx_body_r <= loc_bc + 18'(LOCAL_HDR);
                            tx_bc_r <= loc_bc[7:0];
                            st_r <= ST_TX_FETCH;
                        end
                        else
                        begin
                            plen_r <= fwd_len;
                            st_r <= ST_FWD;
                        end
                    end
                    else if (take_commit)
                    begin
                        if (trig_en)
                            st_r <= (trig_in_r != last_trig_r) ? ST_COPY : ST_IDLE;
                        else
                            st_r <= ST_SCAN;
                    end
                end
                ST_FWD:
                begin
                    wv_r <= cp_r < plen_r;
                    wa_r <= 16'(hdr_len) + cp_r;
                    if (cp_r < plen_r)
                        cp_r <= cp_r + 16'd1;
                    else if (!wv_r)
                        st_r <= ST_HDR;
                end
                ST_HDR:
                begin
                    hdr_ph_r <= 1'b1;
                    if (hdr_ph_r)
                    begin
                        seq_r <= seq_r + SEQ_STEP;
                        pending_r <= 1'b1;
                        st_r <= ST_IDLE;
                    end
                end
                ST_SCAN:
                begin
                    wv_r <= cp_r < span16;
                    // stored copy is unknown after reset, so the first commit in change mode always transfers
                    if (wv_r && (!seeded_r || (out_rdata != sto_rdata)))
                        diff_r <= 1'b1;
                    if (cp_r < span16)
                        cp_r <= cp_r + 16'd1;
                    else if (!wv_r)
                    begin
                        cp_r <= 16'h0000;
                        st_r <= diff_r ? ST_COPY : ST_IDLE;
                    end
                end
                ST_COPY:
                begin
                    // bytes past the counted length stay as they were
                    wv_r <= cp_r < span16;
                    wa_r <= cp_r;
                    if (cp_r < span16)
                        cp_r <= cp_r + 16'd1;
                    else if (!wv_r)
                    begin
                        last_trig_r <= trig_in_r;
                        seeded_r <= 1'b1;
                        // reply is the fieldbus master's answer in request layout
                        if (pending_r)
                        begin
                            tx_local_r <= 1'b0;
                            tx_base_r <= 18'(hdr_len);
                            tx_body_r <= 18'(take16);
                            st_r <= ST_TX_FETCH;
                        end
                        else
                            st_r <= ST_IDLE;
                    end
                end
                ST_TX_FETCH:
                begin
                    oob_r <= body_addr >= 18'(FB_LEN);
                    st_r <= ST_TX_LOAD;
                end
                ST_TX_LOAD:
                begin
                    tx_data_r <= tx_pick;
                    tx_valid_r <= 1'b1;
                    st_r <= ST_TX_SEND;
                end
                ST_TX_SEND:
                begin
                    if (tx_ready)
                    begin
                        tx_valid_r <= 1'b0;
                        tx_idx_r <= tx_idx_r + 18'd1;
                        if (tx_idx_r <= tx_body_r)
                            crc_tx_r <= crc_tx_nxt;
                        if (tx_done)
                        begin
                            pending_r <= 1'b0;
                            st_r <= ST_IDLE;
                        end
                        else
                            st_r <= ST_TX_FETCH;
                    end
                end
                default:
                    st_r <= ST_IDLE;
            endcase
        end
    end

    property p_drop_bad;
        @(posedge clk) disable iff (!arst_n)
        take_frame && !frame_ok_r |=> st_r == ST_IDLE && !in_we;
    endproperty
    a_drop_bad: assert property (p_drop_bad) else $error("bad frame not dropped");

    property p_addr_match;
        @(posedge clk) disable iff (!arst_n)
        (st_r == ST_IDLE) ##1 (st_r == ST_FWD) |-> $past(req_addr_r) == slave_address;
    endproperty
    a_addr_match: assert property (p_addr_match) else $error("foreign frame forwarded");

    property p_seq_step;
        @(posedge clk) disable iff (!arst_n)
        st_r == ST_HDR && hdr_ph_r |=> seq_r == $past(seq_r) + SEQ_STEP && pending_r;
    endproperty
    a_seq_step: assert property (p_seq_step) else $error("counter did not advance");

    property p_len_byte;
        @(posedge clk) disable iff (!arst_n)
        st_r == ST_HDR && !hdr_ph_r && len_en |-> in_we && in_waddr == len_pos
            && in_wdata == 8'(fwd_len);
    endproperty
    a_len_byte: assert property (p_len_byte) else $error("count byte wrong");

    property p_first_addr;
        @(posedge clk) disable iff (!arst_n)
        tx_valid && tx_idx_r == 18'd0 |-> tx_data == slave_address;
    endproperty
    a_first_addr: assert property (p_first_addr) else $error("reply lacks address");

    property p_back_idle;
        @(posedge clk) disable iff (!arst_n)
        tx_done |=> st_r == ST_IDLE && !pending_r && !tx_valid;
    endproperty
    a_back_idle: assert property (p_back_idle) else $error("no return to idle");

    property p_trig_quiet;
        @(posedge clk) disable iff (!arst_n)
        take_commit && trig_en && trig_in_r == last_trig_r |=> st_r == ST_IDLE;
    endproperty
    a_trig_quiet: assert property (p_trig_quiet) else $error("sent without counter change");

    property p_change_quiet;
        @(posedge clk) disable iff (!arst_n)
        st_r == ST_SCAN && cp_r >= span16 && !wv_r && !diff_r |=> st_r == ST_IDLE;
    endproperty
    a_change_quiet: assert property (p_change_quiet) else $error("sent without change");

    property p_copy_limit;
        @(posedge clk) disable iff (!arst_n)
        st_r == ST_COPY && wv_r |-> wa_r < span16;
    endproperty
    a_copy_limit: assert property (p_copy_limit) else $error("copied past count");

    c_local: cover property (@(posedge clk) disable iff (!arst_n)
        take_frame && frame_ok_r && local_regs_en && is_local_fc(req_fc_r));
    c_forward: cover property (@(posedge clk) disable iff (!arst_n)
        st_r == ST_HDR ##1 st_r == ST_IDLE);
    c_reply: cover property (@(posedge clk) disable iff (!arst_n) tx_done && !tx_local_r);

endmodule : modbus_slave_fieldbus_gateway

// file: sim/serial_master_model.sv
// Purpose: serial master that issues requests and gathers the slave's replies
// Assumes: the frame gap is signalled by a frame-end pulse two cycles after the last byte
// Notes: an idle data line shows the inverse of the last byte, never a stale copy
`timescale 1ns/10ps
module serial_master_model (
    input wire logic clk,
    output logic rx_valid = 1'b0,
    output logic [7:0] rx_data = 8'h00,
    output logic rx_frame_end = 1'b0,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready = 1'b1
);
    logic [7:0] got[$];
    logic slow = 1'b0;
    logic [1:0] tick = 2'h0;
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i])
        begin
            c = c ^ {8'h00, q[i]};
            for (int b = 0; b < 8; b++)
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
        end
        return c;
    endfunction : crc16
    // only this side opens an exchange, one frame at a time
    task automatic send_frame(input logic [7:0] q[$]);
        logic [15:0] c;
        c = crc16(q);
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        foreach (q[i])
        begin
            @(negedge clk);
            rx_valid = 1'b1;
            rx_data = q[i];
        end
        @(negedge clk);
        rx_valid = 1'b0;
        rx_data = ~rx_data;
        @(negedge clk);
        rx_frame_end = 1'b1;
        @(negedge clk);
        rx_frame_end = 1'b0;
    endtask : send_frame
    always @(posedge clk)
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
    // slow mode accepts one byte in four cycles to stretch the reply
    always @(negedge clk)
    begin
        tick <= tick + 2'h1;
        tx_ready <= !slow || (tick == 2'h3);
    end
endmodule : serial_master_model

// file: sim/tb_top.sv
// Purpose: self-checking bench for the serial slave gateway
// Assumes: slave address 5a from the switches, default buffer length
// Notes: the fieldbus side is driven directly by the bench
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0, arst_n = 1'b0, trig_en = 1'b0, len_en = 1'b1, loc = 1'b1;
    logic we = 1'b0, commit = 1'b0, rxv, rxe, txv, txr, pend;
    logic [5:0] wa = 6'h00, ra = 6'h00;
    logic [7:0] wd = 8'h00, rxd, txd, rd;
    int failures = 0, checks_done = 0;
    always #2.5 clk = ~clk;
    modbus_slave_fieldbus_gateway i_modbus_slave_fieldbus_gateway (.clk(clk), .arst_n(arst_n),
        .slave_id_high_switch(4'h5), .slave_id_low_switch(4'ha), .trig_en(trig_en),
        .len_en(len_en), .local_regs_en(loc), .rx_valid(rxv), .rx_data(rxd),
        .rx_frame_end(rxe), .tx_valid(txv), .tx_data(txd), .tx_ready(txr), .fb_out_we(we),
        .fb_out_addr(wa), .fb_out_data(wd), .fb_out_commit(commit), .fb_in_addr(ra),
        .fb_in_data(rd), .req_pending(pend));
    serial_master_model i_serial_master_model (.clk(clk), .rx_valid(rxv), .rx_data(rxd),
        .rx_frame_end(rxe), .tx_valid(txv), .tx_data(txd), .tx_ready(txr));
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
        checks_done++;
        if (s !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask : chk
    // the bench acts as fieldbus master, answering in the forwarded layout
    task automatic load(input logic [7:0] q[$]);
        foreach (q[i])
        begin
            @(negedge clk);
            we = 1'b1;
            wa = 6'(i);
            wd = q[i];
        end
        @(negedge clk);
        we = 1'b0;
        commit = 1'b1;
        @(negedge clk);
        commit = 1'b0;
    endtask : load
    task automatic reply(input logic [7:0] e[$]);
        logic [15:0] c;
        int n;
        c = i_serial_master_model.crc16(e);
        e.push_back(c[7:0]);
        e.push_back(c[15:8]);
        for (n = 0; n < 3000 && i_serial_master_model.got.size() < e.size(); n++)
            @(negedge clk);
        chk("reply length", 8'(e.size()), 8'(i_serial_master_model.got.size()));
        if (n == 3000)
            report_and_stop();
        foreach (e[i])
            chk("reply byte", e[i], i_serial_master_model.got[i]);
        i_serial_master_model.got.delete();
    endtask : reply
    task automatic rdin(input logic [5:0] a, input logic [7:0] e);
        @(negedge clk);
        ra = a;
        @(negedge clk);
        chk("fieldbus in byte", e, rd);
    endtask : rdin
    task automatic wait_pend(input logic [7:0] q[$]);
        int n;
        i_serial_master_model.send_frame(q);
        for (n = 0; n < 500 && pend !== 1'b1; n++)
            @(negedge clk);
        chk("request pending", 8'h01, {7'h00, pend});
        if (n == 500)
            report_and_stop();
    endtask : wait_pend
    task automatic s_local;
        load('{8'h04, 8'h11, 8'h22, 8'h33, 8'h44});
        i_serial_master_model.send_frame('{8'h5a, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02});
        reply('{8'h5a, 8'h03, 8'h04, 8'h11, 8'h22, 8'h33, 8'h44});
        i_serial_master_model.slow = 1'b1;
        i_serial_master_model.send_frame('{8'h5a, 8'h01, 8'h00, 8'h03, 8'h00, 8'h08});
        reply('{8'h5a, 8'h01, 8'h01, 8'h11});
        i_serial_master_model.slow = 1'b0;
    endtask : s_local
    task automatic s_drop;
        i_serial_master_model.send_frame('{8'h5b, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01});
        repeat (200) @(negedge clk);
        chk("reply count", 8'h00, 8'(i_serial_master_model.got.size()));
        chk("request pending", 8'h00, {7'h00, pend});
    endtask : s_drop
    task automatic s_fwd;
        loc = 1'b0;
        wait_pend('{8'h5a, 8'h06, 8'h00, 8'h01, 8'h00, 8'h02});
        rdin(6'h00, 8'h05);
        rdin(6'h01, 8'h06);
        rdin(6'h05, 8'h02);
        load('{8'h03, 8'h06, 8'h00, 8'h01});
        reply('{8'h5a, 8'h06, 8'h00, 8'h01});
        repeat (2) @(negedge clk);
        chk("request pending", 8'h00, {7'h00, pend});
    endtask : s_fwd
    task automatic s_trig;
        trig_en = 1'b1;
        wait_pend('{8'h5a, 8'h10, 8'h00, 8'h02});
        rdin(6'h00, 8'h02);
        rdin(6'h01, 8'h03);
        rdin(6'h02, 8'h10);
        load('{8'h09, 8'h02, 8'h10, 8'h00});
        reply('{8'h5a, 8'h10, 8'h00});
        wait_pend('{8'h5a, 8'h11, 8'h00, 8'h02});
        load('{8'h09, 8'h02, 8'h11, 8'h07});
        repeat (100) @(negedge clk);
        chk("reply count", 8'h00, 8'(i_serial_master_model.got.size()));
        load('{8'h0a, 8'h02, 8'h11, 8'h07});
        reply('{8'h5a, 8'h11, 8'h07});
    endtask : s_trig
    initial
    begin
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        s_local();
        s_drop();
        s_fwd();
        s_trig();
        report_and_stop();
    end
endmodule : tb_top
